// ==== logic/gpe_port.sv ====
// sixteen-pin gpio port: register bank, edge detection, interrupts, wake-up
// assumes host reaches registers through a simple single-cycle register port
`timescale 1ns/1ps
module gpe_port #(
    parameter int PINS = 16
) (
    input  wire logic             MCLK,
    input  wire logic             SYS_RST,
    input  wire logic [7:0]       REG_ADDR,
    input  wire logic             REG_WR,
    input  wire logic             REG_RD,
    input  wire logic [31:0]      REG_WDATA,
    output logic      [31:0]      REG_RDATA,
    input  wire logic [PINS-1:0]  PIN_IN,
    output logic      [PINS-1:0]  PIN_OUT,
    output logic      [PINS-1:0]  PIN_OE,
    output logic                  IRQ1_N,
    output logic                  IRQ2_N,
    output logic                  WAKE_REQ,
    input  wire logic             IDLE_ACTIVE,
    output logic                  IFC_CLK_EN
);
    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [PINS-1:0]   stat1_ff;
    logic [PINS-1:0]   stat2_ff;
    logic [PINS-1:0]   en1_ff;
    logic [PINS-1:0]   en2_ff;
    logic [PINS-1:0]   wake_en_ff;
    logic [PINS-1:0]   din;
    logic [PINS-1:0]   dout_ff;
    logic [PINS-1:0]   dir_ff;
    logic [15:0]       edge_lo_ff;
    logic [15:0]       edge_hi_ff;
    logic              auto_gate_ff;
    logic              wake_global_ff;
    gpe_pkg::gpe_idle_e idle_ff;
    logic [2:0]        rst_cnt_ff;
    logic              done_ff;
    logic [PINS-1:0]   idle_pend_ff;
    logic              irq1_ff;
    logic              irq2_ff;
    logic              wake_ff;
    logic [31:0]       rdata_ff;
    logic              bus_busy_ff;

    logic [PINS-1:0]   pin_sync;
    logic [PINS-1:0]   hit;
    logic [31:0]       edge_all;
    logic              soft_rst;
    logic              mod_rst;
    logic [PINS-1:0]   wdat;
    logic [PINS-1:0]   stat_set;

    assign wdat     = REG_WDATA[PINS-1:0];
    assign edge_all = {edge_hi_ff, edge_lo_ff};
    // soft reset acts like the hardware reset on every register except the read data register
    assign soft_rst = REG_WR && (REG_ADDR == gpe_pkg::OFS_SYS_CONFIG)
                      && REG_WDATA[gpe_pkg::CFG_SOFT_RESET_BIT];
    assign mod_rst  = SYS_RST || (rst_cnt_ff != 3'd0);

    // ----------------------------------------------------------------
    // per-pin detectors
    // ----------------------------------------------------------------
    // pin p uses field bits 2p+1:2p of the combined edge vector
    genvar p;
    generate
        for (p = 0; p < PINS; p++) begin : g_pin
            gpe_edge_pin u_edge (
                .MCLK     (MCLK),
                .SYS_RST  (mod_rst),
                .pin_raw  (PIN_IN[p]),
                .edge_sel (edge_all[2*p+1 -: 2]),
                .is_input (dir_ff[p]),
                .pin_sync (pin_sync[p]),
                .hit      (hit[p])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // reset sequencing
    // ----------------------------------------------------------------
    // a short internal sequence so software can poll for completion
    always_ff @(posedge MCLK) begin
        if (SYS_RST || soft_rst) begin
            rst_cnt_ff <= 3'(gpe_pkg::RESET_SEQ_CYCLES);
            done_ff    <= 1'b0;
        end else if (rst_cnt_ff != 3'd0) begin
            rst_cnt_ff <= rst_cnt_ff - 3'd1;
        end else begin
            done_ff    <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // configuration register
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (mod_rst || soft_rst) begin
            auto_gate_ff   <= gpe_pkg::RST_CONFIG[gpe_pkg::CFG_AUTO_GATE_BIT];
            wake_global_ff <= gpe_pkg::RST_CONFIG[gpe_pkg::CFG_WAKE_GLOBAL];
            idle_ff        <= gpe_pkg::IDLE_FORCE;
        end else if (REG_WR && REG_ADDR == gpe_pkg::OFS_SYS_CONFIG) begin
            auto_gate_ff   <= REG_WDATA[gpe_pkg::CFG_AUTO_GATE_BIT];
            wake_global_ff <= REG_WDATA[gpe_pkg::CFG_WAKE_GLOBAL];
            idle_ff        <= gpe_pkg::gpe_idle_e'(REG_WDATA[gpe_pkg::CFG_IDLE_LSB +: 2]);
        end
    end

    // ----------------------------------------------------------------
    // clock gating request
    // ----------------------------------------------------------------
    // the gate itself sits outside; this only says when the clock may stop
    always_ff @(posedge MCLK) begin
        if (mod_rst) begin
            bus_busy_ff <= 1'b0;
        end else begin
            bus_busy_ff <= REG_WR || REG_RD;
        end
    end
    assign IFC_CLK_EN = !auto_gate_ff || REG_WR || REG_RD || bus_busy_ff;

    // ----------------------------------------------------------------
    // enable registers with set and clear aliases
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (mod_rst) begin
            en1_ff <= gpe_pkg::RST_ZERO16;
            en2_ff <= gpe_pkg::RST_ZERO16;
        end else if (REG_WR) begin
            case (REG_ADDR)
                gpe_pkg::OFS_IRQ_EN1: en1_ff <= wdat;
                gpe_pkg::OFS_IRQ_EN2: en2_ff <= wdat;
                gpe_pkg::OFS_CLR_EN1: en1_ff <= en1_ff & ~wdat;
                gpe_pkg::OFS_CLR_EN2: en2_ff <= en2_ff & ~wdat;
                gpe_pkg::OFS_SET_EN1: en1_ff <= en1_ff | wdat;
                gpe_pkg::OFS_SET_EN2: en2_ff <= en2_ff | wdat;
                default: ;
            endcase
        end
    end

    // wake enable and its aliases
    always_ff @(posedge MCLK) begin
        if (mod_rst) begin
            wake_en_ff <= gpe_pkg::RST_ZERO16;
        end else if (REG_WR) begin
            case (REG_ADDR)
                gpe_pkg::OFS_WAKE_EN:  wake_en_ff <= wdat;
                gpe_pkg::OFS_CLR_WAKE: wake_en_ff <= wake_en_ff & ~wdat;
                gpe_pkg::OFS_SET_WAKE: wake_en_ff <= wake_en_ff | wdat;
                default: ;
            endcase
        end
    end

    // output drive and its aliases
    always_ff @(posedge MCLK) begin
        if (mod_rst) begin
            dout_ff <= gpe_pkg::RST_ZERO16;
        end else if (REG_WR) begin
            case (REG_ADDR)
                gpe_pkg::OFS_DATA_OUT: dout_ff <= wdat;
                gpe_pkg::OFS_CLR_DOUT: dout_ff <= dout_ff & ~wdat;
                gpe_pkg::OFS_SET_DOUT: dout_ff <= dout_ff | wdat;
                default: ;
            endcase
        end
    end

    // direction and edge selection
    always_ff @(posedge MCLK) begin
        if (mod_rst) begin
            dir_ff     <= gpe_pkg::RST_DIRECTION;
            edge_lo_ff <= gpe_pkg::RST_ZERO16;
            edge_hi_ff <= gpe_pkg::RST_ZERO16;
        end else if (REG_WR) begin
            case (REG_ADDR)
                gpe_pkg::OFS_DIRECTION: dir_ff     <= wdat;
                gpe_pkg::OFS_EDGE_LOW:  edge_lo_ff <= REG_WDATA[15:0];
                gpe_pkg::OFS_EDGE_HIGH: edge_hi_ff <= REG_WDATA[15:0];
                default: ;
            endcase
        end
    end

    // pins drive only where direction says output
    assign PIN_OUT = dout_ff;
    assign PIN_OE  = ~dir_ff;

    // ----------------------------------------------------------------
    // input sample
    // ----------------------------------------------------------------
    // synchroniser output taken straight, so a change shows after two edges
    // a third stage here would stretch the pin-to-register delay to three
    assign din = pin_sync;

    // ----------------------------------------------------------------
    // idle-time event capture
    // ----------------------------------------------------------------
    // events seen while idle are held and posted once the module is active
    always_ff @(posedge MCLK) begin
        if (mod_rst) begin
            idle_pend_ff <= gpe_pkg::RST_ZERO16;
        end else if (IDLE_ACTIVE) begin
            idle_pend_ff <= idle_pend_ff | hit;
        end else begin
            idle_pend_ff <= gpe_pkg::RST_ZERO16;
        end
    end

    assign stat_set = IDLE_ACTIVE ? '0 : (hit | idle_pend_ff);

    // ----------------------------------------------------------------
    // interrupt status, write one to clear
    // ----------------------------------------------------------------
    // a pin event in the clear cycle wins, so no edge is lost
    always_ff @(posedge MCLK) begin
        if (mod_rst) begin
            stat1_ff <= gpe_pkg::RST_ZERO16;
            stat2_ff <= gpe_pkg::RST_ZERO16;
        end else begin
            stat1_ff <= (stat1_ff & ~((REG_WR && REG_ADDR == gpe_pkg::OFS_IRQ_STAT1)
                        ? wdat : '0)) | stat_set;
            stat2_ff <= (stat2_ff & ~((REG_WR && REG_ADDR == gpe_pkg::OFS_IRQ_STAT2)
                        ? wdat : '0)) | stat_set;
        end
    end

    // ----------------------------------------------------------------
    // interrupt and wake outputs
    // ----------------------------------------------------------------
    // interrupt lines registered from status, hence one cycle behind the status bit; wake registered from the pin events
    always_ff @(posedge MCLK) begin
        if (mod_rst) begin
            irq1_ff <= 1'b0;
            irq2_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            irq1_ff <= |(stat1_ff & en1_ff);
            irq2_ff <= |(stat2_ff & en2_ff);
            wake_ff <= IDLE_ACTIVE && wake_global_ff
                       && (idle_ff != gpe_pkg::IDLE_FORCE)
                       && |((hit | idle_pend_ff) & wake_en_ff);
        end
    end
    assign IRQ1_N   = ~irq1_ff;
    assign IRQ2_N   = ~irq2_ff;
    assign WAKE_REQ = wake_ff;

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // data registered; unmapped offsets read zero
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            rdata_ff <= 32'h0000_0000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                gpe_pkg::OFS_REVISION:   rdata_ff <= {24'h00_0000, gpe_pkg::REVISION_CODE};
                gpe_pkg::OFS_SYS_CONFIG: rdata_ff <= {27'h000_0000, idle_ff,
                                             wake_global_ff, 1'b0, auto_gate_ff};
                gpe_pkg::OFS_SYS_STATUS: rdata_ff <= {31'h0000_0000, done_ff};
                gpe_pkg::OFS_IRQ_STAT1:  rdata_ff <= 32'(stat1_ff);
                gpe_pkg::OFS_IRQ_STAT2:  rdata_ff <= 32'(stat2_ff);
                gpe_pkg::OFS_IRQ_EN1,
                gpe_pkg::OFS_CLR_EN1,
                gpe_pkg::OFS_SET_EN1:    rdata_ff <= 32'(en1_ff);
                gpe_pkg::OFS_IRQ_EN2,
                gpe_pkg::OFS_CLR_EN2,
                gpe_pkg::OFS_SET_EN2:    rdata_ff <= 32'(en2_ff);
                gpe_pkg::OFS_WAKE_EN,
                gpe_pkg::OFS_CLR_WAKE,
                gpe_pkg::OFS_SET_WAKE:   rdata_ff <= 32'(wake_en_ff);
                gpe_pkg::OFS_DATA_IN:    rdata_ff <= 32'(din);
                gpe_pkg::OFS_DATA_OUT,
                gpe_pkg::OFS_CLR_DOUT,
                gpe_pkg::OFS_SET_DOUT:   rdata_ff <= 32'(dout_ff);
                gpe_pkg::OFS_DIRECTION:  rdata_ff <= 32'(dir_ff);
                gpe_pkg::OFS_EDGE_LOW:   rdata_ff <= {16'h0000, edge_lo_ff};
                gpe_pkg::OFS_EDGE_HIGH:  rdata_ff <= {16'h0000, edge_hi_ff};
                default:                 rdata_ff <= 32'h0000_0000;
            endcase
        end
    end
    assign REG_RDATA = rdata_ff;
endmodule

// ==== logic/gpe_pkg.sv ====
// constants for the sixteen-pin gpio port with edge interrupts and wake-up
// assumes a simple byte-addressed register port driven by the host processor
package gpe_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_REVISION   = 8'h00;
    localparam logic [7:0] OFS_SYS_CONFIG = 8'h10;
    localparam logic [7:0] OFS_SYS_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT1  = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN1    = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STAT2  = 8'h20;
    localparam logic [7:0] OFS_IRQ_EN2    = 8'h24;
    localparam logic [7:0] OFS_WAKE_EN    = 8'h28;
    localparam logic [7:0] OFS_DATA_IN    = 8'h2C;
    localparam logic [7:0] OFS_DATA_OUT   = 8'h30;
    localparam logic [7:0] OFS_DIRECTION  = 8'h34;
    localparam logic [7:0] OFS_EDGE_LOW   = 8'h38;
    localparam logic [7:0] OFS_EDGE_HIGH  = 8'h3C;
    localparam logic [7:0] OFS_CLR_EN1    = 8'h9C;
    localparam logic [7:0] OFS_CLR_EN2    = 8'hA4;
    localparam logic [7:0] OFS_CLR_WAKE   = 8'hA8;
    localparam logic [7:0] OFS_CLR_DOUT   = 8'hB0;
    localparam logic [7:0] OFS_SET_EN1    = 8'hDC;
    localparam logic [7:0] OFS_SET_EN2    = 8'hE4;
    localparam logic [7:0] OFS_SET_WAKE   = 8'hE8;
    localparam logic [7:0] OFS_SET_DOUT   = 8'hF0;

    // ----------------------------------------------------------------
    // configuration field positions
    // ----------------------------------------------------------------
    localparam int CFG_AUTO_GATE_BIT  = 0;
    localparam int CFG_SOFT_RESET_BIT = 1;
    localparam int CFG_WAKE_GLOBAL    = 2;
    localparam int CFG_IDLE_LSB       = 3;
    localparam int STAT_DONE_BIT      = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_DIRECTION = 16'hFFFF;
    localparam logic [15:0] RST_ZERO16    = 16'h0000;
    localparam logic [4:0]  RST_CONFIG    = 5'h00;
    // revision code is arbitrary
    localparam logic [7:0]  REVISION_CODE = 8'h10;

    // ----------------------------------------------------------------
    // timing: internal reset sequence length after a soft reset
    // ----------------------------------------------------------------
    localparam int RESET_SEQ_CYCLES = 4;

    // ----------------------------------------------------------------
    // idle policy and edge select encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        IDLE_FORCE = 2'b00,
        IDLE_NONE  = 2'b01,
        IDLE_SMART = 2'b10
    } gpe_idle_e;

    localparam logic [1:0] EDGE_NONE = 2'b00;
    localparam logic [1:0] EDGE_FALL = 2'b01;
    localparam logic [1:0] EDGE_RISE = 2'b10;
    localparam logic [1:0] EDGE_BOTH = 2'b11;
endpackage

// ==== logic/gpe_edge_pin.sv ====
// one pin's edge detector: synchroniser, previous-level and edge select
// assumes the pin level may be asynchronous; two flops before use
`timescale 1ns/1ps
module gpe_edge_pin (
    input  wire logic       MCLK,
    input  wire logic       SYS_RST,
    input  wire logic       pin_raw,
    input  wire logic [1:0] edge_sel,
    input  wire logic       is_input,
    output logic            pin_sync,
    output logic            hit
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // two-flop synchroniser, then one more stage for the edge compare
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= pin_raw;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign pin_sync = sync_ff;

    // edge decode; output pins never detect
    always_comb begin
        hit = 1'b0;
        if (is_input) begin
            case (edge_sel)
                gpe_pkg::EDGE_FALL: hit = prev_ff & ~sync_ff;
                gpe_pkg::EDGE_RISE: hit = ~prev_ff & sync_ff;
                gpe_pkg::EDGE_BOTH: hit = prev_ff ^ sync_ff;
                default:            hit = 1'b0;
            endcase
        end
    end
endmodule

// ==== bench/gpe_port_props.sv ====
// checker for the gpio port: reset levels, drive registers, lines
// assumes it is bound to gpe_port and sees only the top ports
`timescale 1ns/1ps
module gpe_port_props #(
    parameter int PINS = 16
) (
    input wire logic            MCLK,
    input wire logic            SYS_RST,
    input wire logic [7:0]      REG_ADDR,
    input wire logic            REG_WR,
    input wire logic            REG_RD,
    input wire logic [31:0]     REG_WDATA,
    input wire logic [31:0]     REG_RDATA,
    input wire logic [PINS-1:0] PIN_IN,
    input wire logic [PINS-1:0] PIN_OUT,
    input wire logic [PINS-1:0] PIN_OE,
    input wire logic            IRQ1_N,
    input wire logic            IRQ2_N,
    input wire logic            WAKE_REQ,
    input wire logic            IDLE_ACTIVE,
    input wire logic            IFC_CLK_EN
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    // --------
    // settle counter
    // --------
    // eight cycles outlasts the internal reset, so no write is judged early
    logic [3:0]      cnt_ff;
    logic [3:0]      nxt_cnt;
    logic            wr_ok;
    logic [PINS-1:0] wd;
    assign wd = REG_WDATA[PINS-1:0];
    assign wr_ok = REG_WR && cnt_ff == 4'h8;
    always_comb begin
        nxt_cnt = (cnt_ff == 4'h8) ? cnt_ff : cnt_ff + 4'h1;
        if (REG_WR && REG_ADDR == 8'h10 && REG_WDATA[1]) begin
            nxt_cnt = 4'h0;
        end
    end
    always_ff @(posedge MCLK) begin
        cnt_ff <= SYS_RST ? 4'h0 : nxt_cnt;
    end

    // --------
    // properties
    // --------
    AST_RST_OUT: assert property ($fell(SYS_RST) |-> IRQ1_N && IRQ2_N && !WAKE_REQ
        && PIN_OE == '0 && PIN_OUT == '0) else $error("outputs not at reset level");
    AST_DIR_OE: assert property (wr_ok && REG_ADDR == 8'h34 |=>
        PIN_OE == ~$past(wd)) else $error("drive enable not inverse of direction");
    AST_DOUT_SET: assert property (wr_ok && REG_ADDR == 8'hF0 |=>
        PIN_OUT == ($past(PIN_OUT) | $past(wd))) else $error("set alias wrong");
    AST_DOUT_CLR: assert property (wr_ok && REG_ADDR == 8'hB0 |=>
        PIN_OUT == ($past(PIN_OUT) & ~$past(wd))) else $error("clear alias wrong");
    AST_IRQ_MASK: assert property (wr_ok && REG_ADDR == 8'h9C && wd == '1
        |-> ##2 IRQ1_N) else $error("line one active with enables cleared");
    AST_IRQ_HOLD: assert property (!IRQ1_N && !REG_WR && !IDLE_ACTIVE && cnt_ff == 4'h8
        && !$past(REG_WR) |=> !IRQ1_N) else $error("line one released without a write");
    AST_DIN: assert property (cnt_ff == 4'h8 && REG_RD && REG_ADDR == 8'h2C
        && $past(PIN_IN, 3) == PIN_IN && $past(PIN_IN, 2) == PIN_IN && $past(PIN_IN) == PIN_IN
        |=> REG_RDATA[PINS-1:0] == $past(PIN_IN)) else $error("input sample stale");
    AST_WAKE: assert property (WAKE_REQ |-> $past(IDLE_ACTIVE))
        else $error("wake request outside idle");
endmodule

bind gpe_port gpe_port_props #(
    .PINS(PINS)
) u_props (
    .MCLK       (MCLK),
    .SYS_RST    (SYS_RST),
    .REG_ADDR   (REG_ADDR),
    .REG_WR     (REG_WR),
    .REG_RD     (REG_RD),
    .REG_WDATA  (REG_WDATA),
    .REG_RDATA  (REG_RDATA),
    .PIN_IN     (PIN_IN),
    .PIN_OUT    (PIN_OUT),
    .PIN_OE     (PIN_OE),
    .IRQ1_N     (IRQ1_N),
    .IRQ2_N     (IRQ2_N),
    .WAKE_REQ   (WAKE_REQ),
    .IDLE_ACTIVE(IDLE_ACTIVE),
    .IFC_CLK_EN (IFC_CLK_EN)
);

// ==== bench/gpe_pin_model.sv ====
// pad model: the level seen on each gpio pin
// assumes the bench sets undriven pins through ext_level
`timescale 1ns/1ps
module gpe_pin_model (
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    input  wire logic [15:0] ext_level,
    output logic      [15:0] pin_in
);
    // a driven pad reads back its own drive, so the sample sees outputs too
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ==== bench/testbench.sv ====
// bench for the gpio port: registers, edge events, wake, soft reset
// assumes gpe_pkg, gpe_port, the pad model and the checker compile first
`timescale 1ns/1ps
module testbench;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [15:0] pin;
    logic [15:0] pout;
    logic [15:0] poe;
    logic        irq1_n;
    logic        irq2_n;
    logic        wake;
    logic        clk_en;
    logic        idle = 1'b0;
    logic [15:0] ext = 16'h0000;
    logic [31:0] seed = 32'h0000_88F8;
    logic [31:0] exp_q[$];
    int          mismatches = 0;
    int          n_compared = 0;
    int          cycles = 0;

    // 100 MHz clock
    always #5 mclk = ~mclk;

    // --------
    // design and pads
    // --------
    gpe_port #(
        .PINS(16)
    ) u_dut (
        .MCLK       (mclk),
        .SYS_RST    (rst),
        .REG_ADDR   (addr),
        .REG_WR     (wr_en),
        .REG_RD     (rd_en),
        .REG_WDATA  (wdata),
        .REG_RDATA  (rdata),
        .PIN_IN     (pin),
        .PIN_OUT    (pout),
        .PIN_OE     (poe),
        .IRQ1_N     (irq1_n),
        .IRQ2_N     (irq2_n),
        .WAKE_REQ   (wake),
        .IDLE_ACTIVE(idle),
        .IFC_CLK_EN (clk_en)
    );
    gpe_pin_model u_pins (
        .pin_out  (pout),
        .pin_oe   (poe),
        .ext_level(ext),
        .pin_in   (pin)
    );

    // --------
    // helpers
    // --------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        tick(1);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        tick(1);
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        tick(1);
        exp_q.push_back(want);
        addr = a;
        rd_en = 1'b1;
        tick(1);
        rd_en = 1'b0;
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // read data lands one cycle after the strobe; oldest note is the match
    always @(posedge mclk) begin
        if (rd_en) begin
            #2;
            chk(rdata, exp_q.pop_front());
        end
    end
    // hang guard, far above the few hundred cycles needed
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            complete_run();
        end
    end

    // --------
    // scenarios
    // --------
    initial begin
        logic [15:0] v;
        logic [15:0] s;
        int          p;
        tick(10);
        rst = 1'b0;
        tick(8);
        for (int i = 0; i < 16; i++) begin
            p = (i < 11) ? 8'h14 + 4 * i : (i == 11) ? 8'h9C : (i == 12) ? 8'hA4 : 8'h40;
            rd(p[7:0], p == 8'h14 ? 32'h1 : p == 8'h34 ? 32'h0000_FFFF : 32'h0);
        end
        chk({poe, 15'h0000, clk_en}, 32'h0000_0001);
        $display("reset values done");
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14, 32'h0000_0001);
        wr(8'h1C, 32'h0000_0F0F);
        wr(8'h9C, 32'h0000_0101);
        rd(8'h1C, 32'h0000_0E0E);
        rd(8'h9C, 32'h0000_0E0E);
        v = 16'(rnd());
        s = 16'(rnd());
        wr(8'h28, {16'h0000, v});
        wr(8'hE8, {16'h0000, s});
        wr(8'hA8, {16'h0000, v});
        rd(8'hE8, {16'h0000, s & ~v});
        wr(8'h30, {16'h0000, s});
        wr(8'hF0, {16'h0000, v});
        wr(8'hB0, {16'h0000, s});
        rd(8'hB0, {16'h0000, v & ~s});
        $display("aliases done");
        wr(8'h34, 32'h0000_00FF);
        ext = s;
        tick(4);
        chk({16'h0000, poe}, 32'h0000_FF00);
        rd(8'h2C, {16'h0000, (v & ~s & 16'hFF00) | (s & 16'h00FF)});
        ext = 16'h0000;
        wr(8'h34, 32'h0000_FFFF);
        wr(8'hDC, 32'h0000_FFFF);
        wr(8'hA4, 32'h0000_FFFF);
        $display("direction done");
        for (int m = 0; m < 4; m++) begin
            p = 4 * m + 1;
            wr(p < 8 ? 8'h38 : 8'h3C, 32'(m) << (2 * (p % 8)));
            wr(8'h18, 32'h0000_FFFF);
            wr(8'h20, 32'h0000_FFFF);
            ext[p] = 1'b1;
            tick(6);
            s = m[1] ? 16'h0001 << p : 16'h0000;
            chk({31'h0, irq1_n}, {31'h0, ~|s});
            chk({31'h0, irq2_n}, 32'h0000_0001);
            wr(8'h18, 32'h0000_0000);
            rd(8'h18, {16'h0000, s});
            ext[p] = 1'b0;
            tick(6);
            s[p] = s[p] | m[0];
            rd(8'h18, {16'h0000, s});
            rd(8'h20, {16'h0000, s});
        end
        ext[13] = 1'b1;
        tick(6);
        wr(8'h9C, 32'h0000_FFFF);
        tick(2);
        chk({31'h0, irq1_n}, 32'h0000_0001);
        rd(8'h18, 32'h0000_2000);
        wr(8'h18, 32'h0000_FFFF);
        wr(8'h20, 32'h0000_FFFF);
        $display("edge modes done");
        wr(8'h38, 32'h0000_0003);
        wr(8'h28, 32'h0000_0001);
        wr(8'hE4, 32'h0000_0001);
        for (int k = 0; k < 3; k++) begin
            wr(8'h10, k == 0 ? 32'h0000_0014 : k == 1 ? 32'h0000_0004 : 32'h0000_0011);
            idle = 1'b1;
            ext[0] = ~ext[0];
            tick(6);
            chk({31'h0, wake}, 32'(k == 0));
            chk({31'h0, clk_en}, 32'(k != 2));
            idle = 1'b0;
            tick(3);
            chk({31'h0, irq2_n}, 32'h0000_0000);
            rd(8'h20, 32'h0000_0001);
            wr(8'h18, 32'h0000_FFFF);
            wr(8'h20, 32'h0000_FFFF);
        end
        $display("wake done");
        wr(8'h30, 32'h0000_00A5);
        wr(8'h10, 32'h0000_0002);
        rd(8'h14, 32'h0000_0000);
        tick(8);
        rd(8'h10, 32'h0000_0000);
        rd(8'h34, 32'h0000_FFFF);
        chk({16'h0000, pout}, 32'h0000_0000);
        tick(2);
        $display("soft reset done");
        complete_run();
    end
endmodule
